// >>> wrrb_pkg.sv
// shared constants and types of the wireless receiver register bank
package wrrb_pkg;
  localparam logic [7:0] ADDR_MAILBOX = 8'hE0;
  localparam logic [7:0] ADDR_COMP = 8'hE1;
  localparam logic [7:0] ADDR_HEADER = 8'hE2;
  localparam logic [7:0] ADDR_RECT_VOLT = 8'hE3;
  localparam logic [7:0] ADDR_OUT_VOLT = 8'hE4;
  localparam logic [7:0] ADDR_RX_POWER = 8'hE8;
  localparam logic [7:0] ADDR_MODE = 8'hEF;
  localparam logic [7:0] ADDR_PAYLOAD0 = 8'hF1;
  localparam int PAYLOAD_BYTES = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic RESET_SENT_FLAG = 1'b1;
  localparam int MBX_SENT_BIT = 7;
  localparam int MBX_ERR_LSB = 5;
  localparam int MBX_ALIGN_BIT = 3;
  localparam int COMP_SERIES_EN_BIT = 7;
  localparam int COMP_OFFSET_EN_BIT = 6;
  localparam int COMP_OFFSET_LSB = 3;
  localparam int COMP_SCALE_LSB = 0;
  localparam int MODE_ALIGN_BIT = 6;
  localparam int MODE_PROTO_BIT = 0;
  localparam int MODE_RSV_HI_BIT = 7;
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_NO_TX = 2'h1;
  localparam logic [1:0] ERR_BAD_HEADER = 2'h2;
  localparam logic [7:0] HEADER_ILLEGAL = 8'h00;
  // offset codes counted in 39 mW steps: 117, 156, 195, 234, 273 mW
  localparam logic [7:0] OFS_CODE3_CNT = 8'h03;
  localparam logic [7:0] OFS_CODE4_CNT = 8'h04;
  localparam logic [7:0] OFS_CODE5_CNT = 8'h05;
  localparam logic [7:0] OFS_CODE6_CNT = 8'h06;
  localparam logic [7:0] OFS_CODE7_CNT = 8'h07;
  localparam int CLOCK_MHZ = 125;
  localparam int REFRESH_TIME_US = 100;
  localparam int REFRESH_CYCLES = REFRESH_TIME_US * CLOCK_MHZ;
  localparam logic [6:0] I2C_DEV_ADDR = 7'h6C;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

  typedef enum logic [0:0] {PK_IDLE, PK_WAIT} wrrb_pkt_e;
  typedef enum logic [2:0] {
    IC_IDLE, IC_ADDR, IC_ADDR_ACK, IC_WDATA, IC_WACK, IC_RDATA, IC_RACK
  } wrrb_i2c_e;
endpackage : wrrb_pkg

// >>> wrrb_i2c_slave.sv
// i2c slave port with register pointer and auto increment
`timescale 1ns/10ps
`default_nettype none
module wrrb_i2c_slave (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // i2c pins
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  // register access
  output logic [7:0] o_rd_addr,
  input wire logic [7:0] i_rd_data,
  output logic o_wr_stb,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data
);
  import wrrb_pkg::*;

  typedef struct packed {
    logic scl_p;
    logic sda_p;
    wrrb_i2c_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic first;
    logic oe;
    logic wr;
    logic [7:0] waddr;
    logic [7:0] wdata;
  } wrrb_i2c_s;

  localparam wrrb_i2c_s RST = '{scl_p: 1'b1, sda_p: 1'b1, st: IC_IDLE, default: '0};

  wrrb_i2c_s q, d;
  logic rise, fall, start, stop;

  always_comb begin
    d = q;
    d.scl_p = i_scl;
    d.sda_p = i_sda_in;
    d.wr = 1'b0;
    rise = i_scl & ~q.scl_p;
    fall = ~i_scl & q.scl_p;
    start = i_scl & q.scl_p & q.sda_p & ~i_sda_in;
    stop = i_scl & q.scl_p & ~q.sda_p & i_sda_in;
    if (start) begin
      d.st = IC_ADDR;
      d.cnt = '0;
      d.oe = 1'b0;
    end else if (stop) begin
      d.st = IC_IDLE;
      d.oe = 1'b0;
    end else begin
      case (q.st)
        IC_ADDR, IC_WDATA: begin
          if (rise) begin
            d.sh = {q.sh[6:0], i_sda_in};
            d.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == I2C_BYTE_BITS) begin
            if (q.st == IC_ADDR) begin
              if (q.sh[7:1] == I2C_DEV_ADDR) begin
                d.rw = q.sh[0];
                d.oe = 1'b1;
                d.st = IC_ADDR_ACK;
              end else begin
                d.st = IC_IDLE;
              end
            end else begin
              d.oe = 1'b1;
              d.st = IC_WACK;
              if (q.first) begin
                d.ptr = q.sh;
              end else begin
                d.wr = 1'b1;
                d.waddr = q.ptr;
                d.wdata = q.sh;
                d.ptr = q.ptr + 8'h01;
              end
            end
          end
        end
        IC_ADDR_ACK: begin
          if (fall) begin
            d.cnt = '0;
            if (q.rw) begin
              d.sh = i_rd_data;
              d.oe = ~i_rd_data[7];
              d.ptr = q.ptr + 8'h01;
              d.st = IC_RDATA;
            end else begin
              d.oe = 1'b0;
              d.first = 1'b1;
              d.st = IC_WDATA;
            end
          end
        end
        IC_WACK: begin
          if (fall) begin
            d.oe = 1'b0;
            d.cnt = '0;
            d.first = 1'b0;
            d.st = IC_WDATA;
          end
        end
        IC_RDATA: begin
          if (rise) begin
            d.cnt = q.cnt + 4'h1;
          end else if (fall) begin
            if (q.cnt == I2C_BYTE_BITS) begin
              d.oe = 1'b0;
              d.st = IC_RACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.oe = ~q.sh[6];
            end
          end
        end
        IC_RACK: begin
          if (rise && i_sda_in) begin
            d.st = IC_IDLE;
          end else if (fall) begin
            d.sh = i_rd_data;
            d.oe = ~i_rd_data[7];
            d.ptr = q.ptr + 8'h01;
            d.cnt = '0;
            d.st = IC_RDATA;
          end
        end
        default: d.st = IC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe = q.oe;
  assign o_rd_addr = q.ptr;
  assign o_wr_stb = q.wr;
  assign o_wr_addr = q.waddr;
  assign o_wr_data = q.wdata;
endmodule : wrrb_i2c_slave
`default_nettype wire

// >>> wrrb_register_bank.sv
// host register bank of the wireless power receiver
`timescale 1ns/10ps
`default_nettype none
module wrrb_register_bank #(
  parameter int REFRESH_PERIOD = wrrb_pkg::REFRESH_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // i2c pins
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  // measurements and status
  input wire logic i_below_uvlo,
  input wire logic [7:0] i_rectifier_voltage,
  input wire logic [7:0] i_regulated_output_voltage,
  input wire logic [7:0] i_measured_power,
  input wire logic [7:0] i_series_loss_power,
  input wire logic i_protocol_second,
  input wire logic i_align_active,
  // custom packet to control processor
  input wire logic i_tx_present,
  input wire logic i_comm_slot,
  output logic o_pkt_pending,
  output logic o_pkt_send,
  output logic [7:0] o_pkt_header,
  output logic [8*wrrb_pkg::PAYLOAD_BYTES-1:0] o_pkt_payload,
  // controls
  output logic o_align_request,
  output logic [7:0] o_received_power_reading
);
  import wrrb_pkg::*;

  typedef struct packed {
    logic [4:0] mbx_ctl;
    logic custom_packet_sent_flag;
    logic [1:0] custom_packet_error_code;
    logic [7:0] comp;
    logic [7:0] header;
    logic [7:0] rect_volt;
    logic [7:0] out_volt;
    logic [7:0] rx_power;
    logic mode_rsv_hi;
    logic [4:0] mode_rsv;
    logic [PAYLOAD_BYTES-1:0][7:0] payload;
    wrrb_pkt_e pkt_st;
    logic [31:0] tick;
    logic [7:0] pkt_header;
    logic [PAYLOAD_BYTES-1:0][7:0] pkt_payload;
  } wrrb_bank_s;

  localparam wrrb_bank_s RST = '{
    custom_packet_sent_flag: RESET_SENT_FLAG, pkt_st: PK_IDLE, default: '0};

  wrrb_bank_s q, d;
  logic [7:0] rd_addr, rd_data, wr_addr, wr_data;
  logic wr_stb;
  logic [9:0] scaled_loss;
  logic [7:0] offset_cnt;
  logic [10:0] power_sum;
  logic [7:0] power_word;
  logic [7:0] payload_index;

  wrrb_i2c_slave u_i2c (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_scl(i_scl),
    .i_sda_in(i_sda_in),
    .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data),
    .o_wr_stb(wr_stb),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data)
  );

  // received power with loss and offset terms
  always_comb begin
    case (q.comp[COMP_SCALE_LSB +: 3])
      3'h2: scaled_loss = {1'b0, i_series_loss_power, 1'b0};
      3'h3: scaled_loss = 10'({2'b00, i_series_loss_power} * 10'h003);
      3'h4: scaled_loss = {i_series_loss_power, 2'b00};
      3'h7: scaled_loss = {3'b000, i_series_loss_power[7:1]};
      default: scaled_loss = {2'b00, i_series_loss_power};
    endcase
    case (q.comp[COMP_OFFSET_LSB +: 3])
      3'h3: offset_cnt = OFS_CODE3_CNT;
      3'h4: offset_cnt = OFS_CODE4_CNT;
      3'h5: offset_cnt = OFS_CODE5_CNT;
      3'h6: offset_cnt = OFS_CODE6_CNT;
      3'h7: offset_cnt = OFS_CODE7_CNT;
      default: offset_cnt = RESET_BYTE;
    endcase
    power_sum = {3'b000, i_measured_power};
    if (q.comp[COMP_SERIES_EN_BIT]) begin
      power_sum = power_sum + {1'b0, scaled_loss};
    end
    if (q.comp[COMP_OFFSET_EN_BIT]) begin
      power_sum = power_sum + {3'b000, offset_cnt};
    end
    power_word = (power_sum > 11'h0FF) ? 8'hFF : power_sum[7:0];
  end

  // read mux
  always_comb begin
    payload_index = rd_addr - ADDR_PAYLOAD0;
    case (rd_addr)
      ADDR_MAILBOX: rd_data = {q.custom_packet_sent_flag, q.custom_packet_error_code, q.mbx_ctl};
      ADDR_COMP: rd_data = q.comp;
      ADDR_HEADER: rd_data = q.header;
      ADDR_RECT_VOLT: rd_data = q.rect_volt;
      ADDR_OUT_VOLT: rd_data = q.out_volt;
      ADDR_RX_POWER: rd_data = q.rx_power;
      ADDR_MODE: rd_data = {q.mode_rsv_hi, i_align_active, q.mode_rsv, i_protocol_second};
      default: begin
        rd_data = RESET_BYTE;
        if (payload_index < 8'(PAYLOAD_BYTES)) begin
          rd_data = q.payload[payload_index[1:0]];
        end
      end
    endcase
  end

  always_comb begin
    d = q;
    o_pkt_send = 1'b0;
    // periodic readback refresh
    if (q.tick >= 32'(REFRESH_PERIOD - 1)) begin
      d.tick = '0;
      d.rect_volt = i_rectifier_voltage;
      d.out_volt = i_regulated_output_voltage;
      d.rx_power = power_word;
    end else begin
      d.tick = q.tick + 32'h1;
    end
    // host writes; rectifier voltage and status bits ignore them, but out_volt and rx_power take them until the next refresh
    if (wr_stb) begin
      case (wr_addr)
        ADDR_MAILBOX: begin
          d.mbx_ctl = wr_data[4:0];
          if (!wr_data[MBX_SENT_BIT] && q.pkt_st == PK_IDLE) begin
            d.custom_packet_sent_flag = 1'b0;
            d.pkt_header = q.header;
            d.pkt_payload = q.payload;
            if (q.header == HEADER_ILLEGAL) begin
              d.custom_packet_error_code = ERR_BAD_HEADER;
              d.custom_packet_sent_flag = 1'b1;
            end else begin
              d.custom_packet_error_code = ERR_NONE;
              d.pkt_st = PK_WAIT;
            end
          end
        end
        ADDR_COMP: d.comp = wr_data;
        ADDR_HEADER: d.header = wr_data;
        ADDR_OUT_VOLT: d.out_volt = wr_data;
        ADDR_RX_POWER: d.rx_power = wr_data;
        ADDR_MODE: begin
          d.mode_rsv_hi = wr_data[MODE_RSV_HI_BIT];
          d.mode_rsv = wr_data[5:1];
        end
        default: begin
          for (int i = 0; i < PAYLOAD_BYTES; i++) begin
            if (wr_addr == ADDR_PAYLOAD0 + 8'(i)) begin
              d.payload[i] = wr_data;
            end
          end
        end
      endcase
    end
    // packet hand-off to the control processor
    case (q.pkt_st)
      PK_IDLE: ;
      PK_WAIT: begin
        if (!i_tx_present) begin
          d.custom_packet_error_code = ERR_NO_TX;
          d.custom_packet_sent_flag = 1'b1;
          d.pkt_st = PK_IDLE;
        end else if (i_comm_slot) begin
          o_pkt_send = 1'b1;
          d.custom_packet_sent_flag = 1'b1;
          d.pkt_st = PK_IDLE;
        end
      end
      default: d.pkt_st = PK_IDLE;
    endcase
    if (i_below_uvlo) begin
      d = RST;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign o_pkt_pending = (q.pkt_st == PK_WAIT);
  assign o_pkt_header = q.pkt_header;
  assign o_pkt_payload = q.pkt_payload;
  assign o_align_request = q.mbx_ctl[MBX_ALIGN_BIT];
  assign o_received_power_reading = q.rx_power;
endmodule : wrrb_register_bank
`default_nettype wire

// >>> wrrb_monitor.sv
// checker of the register bank packet and lockout behaviour
`timescale 1ns/10ps
`default_nettype none
module wrrb_monitor
  import wrrb_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // watched inputs
  input wire logic i_below_uvlo,
  input wire logic i_tx_present,
  input wire logic i_comm_slot,
  // watched outputs
  input wire logic o_pkt_pending,
  input wire logic o_pkt_send,
  input wire logic [7:0] o_pkt_header,
  input wire logic [8*wrrb_pkg::PAYLOAD_BYTES-1:0] o_pkt_payload,
  input wire logic o_align_request,
  input wire logic [7:0] o_received_power_reading
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence s_ready;
    o_pkt_pending && i_tx_present && i_comm_slot;
  endsequence
  sequence s_held;
    o_pkt_pending && !i_below_uvlo ##1 o_pkt_pending;
  endsequence
  property p_send_cause;
    o_pkt_send |-> o_pkt_pending && i_tx_present && i_comm_slot;
  endproperty
  property p_send_on_slot;
    s_ready |-> o_pkt_send;
  endproperty
  property p_send_done;
    s_ready |=> !o_pkt_pending && !o_pkt_send;
  endproperty
  property p_wait_slot;
    o_pkt_pending && i_tx_present && !i_comm_slot && !i_below_uvlo |=> o_pkt_pending;
  endproperty
  property p_no_tx;
    o_pkt_pending && !i_tx_present |=> !o_pkt_pending;
  endproperty
  property p_hdr_valid;
    $rose(o_pkt_pending) |-> o_pkt_header != HEADER_ILLEGAL;
  endproperty
  property p_hold;
    s_held |-> $stable(o_pkt_payload) && $stable(o_pkt_header);
  endproperty
  property p_uvlo;
    i_below_uvlo |=> !o_pkt_pending && !o_align_request && o_pkt_header == 8'h00
      && o_received_power_reading == 8'h00;
  endproperty
  a_send_cause: assert property (p_send_cause) else $error("send without cause");
  a_send_on_slot: assert property (p_send_on_slot) else $error("slot missed");
  a_send_done: assert property (p_send_done) else $error("still pending");
  a_wait_slot: assert property (p_wait_slot) else $error("packet lost");
  a_no_tx: assert property (p_no_tx) else $error("no abort");
  a_hdr_valid: assert property (p_hdr_valid) else $error("bad header queued");
  a_hold: assert property (p_hold) else $error("packet changed");
  a_uvlo: assert property (p_uvlo) else $error("lockout reset missing");
endmodule : wrrb_monitor
bind wrrb_register_bank wrrb_monitor wrrb_monitor_i (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_below_uvlo(i_below_uvlo),
  .i_tx_present(i_tx_present), .i_comm_slot(i_comm_slot), .o_pkt_pending(o_pkt_pending),
  .o_pkt_send(o_pkt_send), .o_pkt_header(o_pkt_header), .o_pkt_payload(o_pkt_payload),
  .o_align_request(o_align_request), .o_received_power_reading(o_received_power_reading)
);
`default_nettype wire

// >>> wrrb_host_model.sv
// i2c host model that reaches the register bank
`timescale 1ns/10ps
`default_nettype none
module wrrb_host_model (
  // clock
  input wire logic i_clock,
  // i2c pins
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  import wrrb_pkg::*;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic hold;
    repeat (4) @(posedge i_clock);
  endtask : hold
  // data changes only while scl is low
  task automatic bit_io(input logic b, output logic r);
    o_sda_low <= !b;
    hold();
    o_scl <= 1'b1;
    hold();
    r = i_sda;
    o_scl <= 1'b0;
    hold();
  endtask : bit_io
  task automatic start;
    o_sda_low <= 1'b0;
    hold();
    o_scl <= 1'b1;
    hold();
    o_sda_low <= 1'b1;
    hold();
    o_scl <= 1'b0;
    hold();
  endtask : start
  task automatic stop;
    o_sda_low <= 1'b1;
    hold();
    o_scl <= 1'b1;
    hold();
    o_sda_low <= 1'b0;
    hold();
  endtask : stop
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(last, a);
  endtask : xfer
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    start();
    xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, d);
    xfer(addr, 1'b1, d);
    xfer(data, 1'b1, d);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    logic [7:0] d;
    start();
    xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, d);
    xfer(addr, 1'b1, d);
    start();
    xfer({I2C_DEV_ADDR, 1'b1}, 1'b1, d);
    xfer(8'hFF, 1'b1, data);
    stop();
  endtask : rd
endmodule : wrrb_host_model
`default_nettype wire

// >>> wrrb_register_bank_tb.sv
// self-checking testbench of the wireless receiver register bank
`timescale 1ns/10ps
`default_nettype none
module wrrb_register_bank_tb;
  import wrrb_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic uvlo = 1'b0, proto = 1'b0, align = 1'b0, txp = 1'b0, slot = 1'b0;
  logic [7:0] vr = 8'h00, vo = 8'h00, pw = 8'h00, ls = 8'h00, c, b [4];
  wire logic scl, sda_low, sda_oe, sda_out, send, pend, alreq;
  wire logic [7:0] hdr, pread;
  wire logic [31:0] pl;
  wire logic sda = !(sda_low || (sda_oe && !sda_out));
  int n_mismatch = 0;
  int comparisons = 0;
  int seed = 32'hA36C;
  logic [7:0] ra [9] = '{8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE8, 8'hEF, 8'hF1, 8'hF4};
  always #4 i_clock = ~i_clock;
  wrrb_register_bank #(.REFRESH_PERIOD(8)) wrrb_register_bank_i (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_scl(scl), .i_sda_in(sda), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .i_below_uvlo(uvlo), .i_rectifier_voltage(vr),
    .i_regulated_output_voltage(vo), .i_measured_power(pw), .i_series_loss_power(ls),
    .i_protocol_second(proto), .i_align_active(align), .i_tx_present(txp),
    .i_comm_slot(slot), .o_pkt_pending(pend), .o_pkt_send(send), .o_pkt_header(hdr),
    .o_pkt_payload(pl), .o_align_request(alreq), .o_received_power_reading(pread)
  );
  wrrb_host_model wrrb_host_model_i (
    .i_clock(i_clock), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low)
  );
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    wrrb_host_model_i.rd(a, d);
    chk(nm, {24'h0, d}, {24'h0, exp});
  endtask : rchk
  // reference received power in 39 mW counts
  function automatic int epow(int raw, int loss, int comp);
    int s, o, l;
    s = comp & 7;
    o = (comp >> 3) & 7;
    l = s == 2 ? 2 * loss : s == 3 ? 3 * loss : s == 4 ? 4 * loss : s == 7 ? loss / 2 : loss;
    epow = raw + (((comp >> 7) & 1) ? l : 0) + (((comp >> 6) & 1) && o >= 3 ? o : 0);
    if (epow > 255) epow = 255;
  endfunction : epow
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (60000) @(posedge i_clock);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (20) @(posedge i_clock);
    foreach (ra[k]) rchk("reset", ra[k], k == 0 ? 8'h80 : 8'h00);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      c = {i != 0, i != 5, i[2:0], i[2:0]};
      vr <= 8'($random(seed));
      vo <= 8'($random(seed));
      pw <= 8'($random(seed)) & 8'h7F;
      ls <= 8'($random(seed)) & 8'h1F;
      proto <= i[0];
      align <= i[1];
      wrrb_host_model_i.wr(8'hE1, c);
      repeat (20) @(posedge i_clock);
      @(negedge i_clock);
      chk("power", {24'h0, pread}, epow(pw, ls, c));
      @(posedge i_clock);
      rchk("rect", 8'hE3, vr);
      rchk("out_volt", 8'hE4, vo);
      rchk("mode", 8'hEF, {1'b0, align, 5'h00, proto});
    end
    wrrb_host_model_i.wr(8'hEF, 8'hFF);
    rchk("mode_ro", 8'hEF, {1'b1, align, 5'h1F, proto});
    $display("readback done");
    foreach (b[k]) begin
      b[k] = 8'($random(seed));
      wrrb_host_model_i.wr(8'(8'hF1 + k), b[k]);
    end
    wrrb_host_model_i.wr(8'hE0, 8'h00);
    rchk("illegal", 8'hE0, 8'hC0);
    txp <= 1'b1;
    wrrb_host_model_i.wr(8'hE2, 8'h5A);
    wrrb_host_model_i.wr(8'hE0, 8'h08);
    rchk("pending", 8'hE0, 8'h08);
    chk("header", {23'h0, pend, hdr}, 32'h15A);
    chk("payload", pl, {b[3], b[2], b[1], b[0]});
    chk("align_req", {31'h0, alreq}, 32'h1);
    @(posedge i_clock) slot <= 1'b1;
    @(negedge i_clock) chk("send", {31'h0, send}, 32'h1);
    @(posedge i_clock) slot <= 1'b0;
    rchk("sent", 8'hE0, 8'h88);
    txp <= 1'b0;
    wrrb_host_model_i.wr(8'hE0, 8'h08);
    rchk("notx", 8'hE0, 8'hA8);
    $display("packet done");
    @(posedge i_clock) uvlo <= 1'b1;
    repeat (3) @(posedge i_clock);
    uvlo <= 1'b0;
    chk("align_req", {31'h0, alreq}, 32'h0);
    foreach (ra[k]) if (k < 3 || k > 6) rchk("uvlo", ra[k], k == 0 ? 8'h80 : 8'h00);
    $display("lockout done");
    wrap_up();
  end
endmodule : wrrb_register_bank_tb
`default_nettype wire
